/* src/sar_adc_conversion_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_interface #(
   parameter bit BYTE_VARIANT = 1'b1
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_conv_clk,
   input wire logic i_cs_n,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic i_byte_select,
   input wire logic i_cmp_high,
   output logic [sar_adc_pkg::RESULT_BITS-1:0] o_result_bus_out,
   output logic o_result_bus_oe,
   output logic o_busy_out,
   output logic o_busy_oe,
   output logic o_done_out,
   output logic o_done_oe,
   output logic [sar_adc_pkg::RESULT_BITS-1:0] o_dac_code,
   output logic o_autozero,
   output logic o_sample_pos,
   output logic o_sample_neg
);
   import sar_adc_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [5:0] pin_raw;
   logic [5:0] meta_reg;
   logic [5:0] pin_reg;
   logic conv_lvl, cs_n_s, wr_n_s, rd_n_s, bsel_s, cmp_s;
   logic conv_prev_reg;
   logic conv_rise, conv_edge, sel, wr_start, rd_access;
   assign pin_raw = {i_conv_clk, i_cs_n, i_wr_n, i_rd_n,
                     i_byte_select, i_cmp_high};
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         meta_reg <= PIN_IDLE;
         pin_reg <= PIN_IDLE;
      end else begin
         meta_reg <= pin_raw;
         pin_reg <= meta_reg;
      end
   end
   assign {conv_lvl, cs_n_s, wr_n_s, rd_n_s, bsel_s, cmp_s} = pin_reg;
   // both edges count: the phase timing has half-clock steps
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         conv_prev_reg <= 1'b0;
      end else begin
         conv_prev_reg <= conv_lvl;
      end
   end
   assign conv_rise = conv_lvl & ~conv_prev_reg;
   assign conv_edge = conv_lvl ^ conv_prev_reg;

   // ------------------------------------------------------------
   // strobe decode
   // ------------------------------------------------------------
   assign sel = ~cs_n_s;
   assign wr_start = sel & ~wr_n_s & rd_n_s;
   assign rd_access = sel & ~rd_n_s & wr_n_s;

   // ------------------------------------------------------------
   // divide-by-4 synchronisation counter
   // ------------------------------------------------------------
   logic [1:0] div_reg;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         div_reg <= 2'h0;
      end else if (conv_rise) begin
         div_reg <= div_reg + 2'h1;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   conv_state_e state_reg, state_next;
   logic [2:0] half_reg;
   logic [3:0] bit_idx_reg;
   logic decide, hold_pos, xfer_done, enter_init;
   assign decide = (state_reg == ST_APPROX) && conv_edge
                   && (half_reg == DECIDE_LAST);
   assign hold_pos = (state_reg == ST_APPROX) && conv_edge
                     && (half_reg == HOLD_LAST)
                     && (bit_idx_reg == MSB_IDX);
   assign xfer_done = (state_reg == ST_XFER) && conv_edge
                      && (half_reg == XFER_LAST);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (wr_start) begin
               state_next = ST_INIT;
            end
         end
         ST_INIT: begin
            if (wr_n_s) begin
               state_next = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (wr_start) begin
               state_next = ST_INIT;
            end else if (conv_rise && div_reg == DIV_LAST) begin
               state_next = ST_APPROX;
            end
         end
         ST_APPROX: begin
            if (wr_start) begin
               state_next = ST_INIT;
            end else if (decide && bit_idx_reg == 4'h0) begin
               state_next = ST_XFER;
            end
         end
         ST_XFER: begin
            if (wr_start) begin
               state_next = ST_INIT;
            end else if (xfer_done) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end
   assign enter_init = (state_next == ST_INIT) && (state_reg != ST_INIT);
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end
   // half-period count within a bit test or the transfer wait
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         half_reg <= 3'h0;
      end else if (state_next != state_reg) begin
         half_reg <= 3'h0;
      end else if (conv_edge) begin
         half_reg <= half_reg + 3'h1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         bit_idx_reg <= MSB_IDX;
      end else if (state_next == ST_APPROX && state_reg == ST_SYNC) begin
         bit_idx_reg <= MSB_IDX;
      end else if (decide && bit_idx_reg != 4'h0) begin
         bit_idx_reg <= bit_idx_reg - 4'h1;
      end
   end

   // ------------------------------------------------------------
   // approximation register
   // ------------------------------------------------------------
   logic [RESULT_BITS-1:0] sar_reg, result_reg;
   function automatic logic [RESULT_BITS-1:0] trial_step(
      input logic [RESULT_BITS-1:0] code,
      input logic [3:0] idx,
      input logic keep
   );
      logic [RESULT_BITS-1:0] c;
      c = code;
      c[idx] = keep;
      if (idx != 4'h0) begin
         c[idx - 4'h1] = 1'b1;
      end
      return c;
   endfunction
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sar_reg <= RESULT_RESET;
      end else if (enter_init) begin
         sar_reg <= DAC_FULL_SCALE;
      end else if (state_next == ST_APPROX && state_reg == ST_SYNC) begin
         sar_reg <= MSB_TRIAL;
      end else if (decide) begin
         sar_reg <= trial_step(sar_reg, bit_idx_reg, cmp_s);
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         result_reg <= RESULT_RESET;
      end else if (xfer_done) begin
         result_reg <= sar_reg;
      end
   end

   // ------------------------------------------------------------
   // completion flag
   // ------------------------------------------------------------
   // one flag stands for done, busy and end of conversion;
   // a completion landing with a new start still sets it first
   logic complete_reg;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         complete_reg <= 1'b0;
      end else if (xfer_done) begin
         complete_reg <= 1'b1;
      end else if (state_reg == ST_INIT) begin
         complete_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // analog front-end controls
   // ------------------------------------------------------------
   // outside a conversion nothing changes, so the held input survives
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_autozero <= 1'b0;
      end else if (enter_init) begin
         o_autozero <= 1'b1;
      end else if (state_next == ST_SYNC) begin
         o_autozero <= 1'b0;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_sample_pos <= 1'b0;
         o_sample_neg <= 1'b0;
      end else if (enter_init) begin
         o_sample_pos <= 1'b1;
         o_sample_neg <= 1'b0;
      end else if (hold_pos) begin
         o_sample_pos <= 1'b0;
         o_sample_neg <= 1'b1;
      end
   end
   assign o_dac_code = sar_reg;
   // ------------------------------------------------------------
   // open-drain flags
   // ------------------------------------------------------------
   assign o_done_out = 1'b0;
   assign o_done_oe = complete_reg;
   assign o_busy_out = 1'b0;
   assign o_busy_oe = rd_access & ~complete_reg;
   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   read_if rif ();
   assign rif.result = result_reg;
   assign rif.eoc = complete_reg;
   assign rif.rd_sel = rd_access;
   assign rif.byte_select = bsel_s;
   read_port #(
      .BYTE_VARIANT(BYTE_VARIANT)
   ) u_read_port (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .rd(rif.port),
      .o_bus_data(o_result_bus_out),
      .o_bus_oe(o_result_bus_oe)
   );

   // ------------------------------------------------------------
   // check helpers
   // ------------------------------------------------------------
   logic [5:0] total_rise_reg, approx_rise_reg;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || state_reg == ST_INIT) begin
         total_rise_reg <= 6'h00;
      end else if (conv_rise && state_reg != ST_IDLE) begin
         total_rise_reg <= total_rise_reg + 6'h01;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || state_reg == ST_SYNC) begin
         approx_rise_reg <= 6'h00;
      end else if (conv_rise && state_reg == ST_APPROX) begin
         approx_rise_reg <= approx_rise_reg + 6'h01;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_ignore_unselected: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_reg == ST_IDLE && !sel) |=> state_reg == ST_IDLE)
      else $error("strobe acted while deselected");
   a_start_enters_init: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(wr_start) |=> state_reg == ST_INIT)
      else $error("write strobe did not start");
   a_init_setup: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      state_reg == ST_INIT |-> (o_dac_code == DAC_FULL_SCALE)
      && o_autozero && o_sample_pos && !o_sample_neg)
      else $error("init phase setup wrong");
   a_sync_delay: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(state_reg == ST_APPROX) |-> (total_rise_reg >= 6'h01)
      && (total_rise_reg <= SYNC_MAX_CLKS))
      else $error("approximation start delay out of range");
   // two rises and the following fall: 2.5 clocks into the phase
   a_hold_then_neg: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_sample_neg) |-> !o_sample_pos
      && (approx_rise_reg == 6'h02) && (bit_idx_reg == MSB_IDX))
      else $error("positive hold point wrong");
   a_approx_length: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(state_reg == ST_XFER) |-> approx_rise_reg == APPROX_CLKS)
      else $error("approximation not 40 clocks");
   a_xfer_latch: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(complete_reg) |-> (result_reg == $past(sar_reg))
      && ($past(state_reg) == ST_XFER))
      else $error("result not latched at completion");
   a_conv_time: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(complete_reg) |-> (total_rise_reg >= CONV_MIN_CLKS)
      && (total_rise_reg <= CONV_MAX_CLKS))
      else $error("conversion time out of range");
   a_start_clears: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      state_reg == ST_INIT |=> !complete_reg && !o_done_oe)
      else $error("new start kept complete flags");
   a_done_float: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      state_reg == ST_APPROX |-> !o_done_oe)
      else $error("done pulled low during conversion");
   a_busy_read_only: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_busy_oe |-> rd_access && !complete_reg && !o_busy_out)
      else $error("busy driven outside a read");
   a_idle_holds: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_reg == ST_IDLE && !wr_start) |=>
      $stable(o_sample_neg) && $stable(o_dac_code))
      else $error("idle disturbed held conditions");
endmodule
`default_nettype wire

/* include/sar_adc_pkg.sv */
package sar_adc_pkg;
   localparam int RESULT_BITS = 10;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [9:0] DAC_FULL_SCALE = 10'h3FF;
   localparam logic [9:0] MSB_TRIAL = 10'h200;
   localparam logic [3:0] MSB_IDX = 4'h9;
   localparam logic [1:0] DIV_LAST = 2'h3;
   localparam logic [2:0] HOLD_LAST = 3'h4;
   localparam logic [2:0] DECIDE_LAST = 3'h7;
   localparam logic [2:0] XFER_LAST = 3'h3;
   localparam logic [5:0] SYNC_MAX_CLKS = 6'h04;
   localparam logic [5:0] APPROX_CLKS = 6'h28;
   localparam logic [5:0] CONV_MIN_CLKS = 6'h2A;
   localparam logic [5:0] CONV_MAX_CLKS = 6'h2E;
   localparam logic [5:0] PIN_IDLE = 6'h1C;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_INIT = 5'h02,
      ST_SYNC = 5'h04,
      ST_APPROX = 5'h08,
      ST_XFER = 5'h10
   } conv_state_e;
endpackage

/* include/read_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface read_if;
   logic [9:0] result;
   logic eoc;
   logic rd_sel;
   logic byte_select;
   modport core (output result, eoc, rd_sel, byte_select);
   modport port (input result, eoc, rd_sel, byte_select);
endinterface
`default_nettype wire

/* src/read_port.sv */
`timescale 1ns/1ps
`default_nettype none
module read_port #(
   parameter bit BYTE_VARIANT = 1'b1
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   read_if.port rd,
   output logic [sar_adc_pkg::RESULT_BITS-1:0] o_bus_data,
   output logic o_bus_oe
);
   import sar_adc_pkg::*;

   // ------------------------------------------------------------
   // word formatting
   // ------------------------------------------------------------
   function automatic logic [RESULT_BITS-1:0] read_word(
      input logic [RESULT_BITS-1:0] res,
      input logic eoc,
      input logic hi
   );
      logic [RESULT_BITS-1:0] w;
      w = res;
      if (BYTE_VARIANT && hi) begin
         w = {2'h0, eoc, 5'h00, res[9:8]};
      end else if (BYTE_VARIANT) begin
         w = {2'h0, res[7:0]};
      end
      return w;
   endfunction

   // ------------------------------------------------------------
   // bus drive
   // ------------------------------------------------------------
   // data registered so the pins never glitch mid-read
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_bus_data <= RESULT_RESET;
      end else if (rd.rd_sel) begin
         o_bus_data <= read_word(rd.result, rd.eoc, rd.byte_select);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_bus_oe <= 1'b0;
      end else begin
         o_bus_oe <= rd.rd_sel;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_bus_quiet: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !rd.rd_sel |=> !o_bus_oe)
      else $error("bus driven outside a read");

   a_low_byte: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (BYTE_VARIANT && rd.rd_sel && !rd.byte_select) |=>
      (o_bus_data[7:0] == $past(rd.result[7:0])) && o_bus_oe)
      else $error("low byte read wrong");

   a_high_byte: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (BYTE_VARIANT && rd.rd_sel && rd.byte_select) |=>
      (o_bus_data[7] == $past(rd.eoc)) && (o_bus_data[6:2] == 5'h00)
      && (o_bus_data[1:0] == $past(rd.result[9:8])))
      else $error("high byte read wrong");

   a_wide_word: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!BYTE_VARIANT && rd.rd_sel) |=>
      (o_bus_data == $past(rd.result)) && o_bus_oe)
      else $error("wide read wrong");
endmodule
`default_nettype wire

/* tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic i_sys_clk,
   input wire logic [9:0] i_dac_code,
   input wire logic [9:0] i_target,
   input wire logic [9:0] i_bus,
   input wire logic [9:0] i_wbus,
   input wire logic i_bus_oe,
   input wire logic i_busy_pin,
   output logic o_cs_n,
   output logic o_wr_n,
   output logic o_rd_n,
   output logic o_byte_select,
   output logic o_conv_clk,
   output logic o_cmp_high
);
   // ------------------------------------------------
   // clock source and comparator
   // ------------------------------------------------
   initial begin
      o_cs_n = 1'h1;
      o_wr_n = 1'h1;
      o_rd_n = 1'h1;
      o_byte_select = 1'h0;
      o_conv_clk = 1'h0;
   end
   // 400 ns period, 50/50 mark-space
   always #200 o_conv_clk = ~o_conv_clk;
   // ideal comparator: trial kept while not above the input
   assign o_cmp_high = (i_dac_code <= i_target);
   // ------------------------------------------------
   // bus cycles
   // ------------------------------------------------
   task automatic start(input int w, input logic cs);
      @(posedge i_sys_clk);
      #2;
      o_cs_n = cs;
      o_wr_n = 1'h0;
      repeat (w) @(posedge i_sys_clk);
      #2;
      o_wr_n = 1'h1;
      @(posedge i_sys_clk);
      #2;
      o_cs_n = 1'h1;
   endtask
   // strobes held until the answer is sampled, then released
   task automatic access(input logic bs, input logic cs,
         output logic [9:0] d, output logic [9:0] wd,
         output logic oe, output logic busy);
      @(posedge i_sys_clk);
      #2;
      o_cs_n = cs;
      o_rd_n = 1'h0;
      o_byte_select = bs;
      repeat (4) @(posedge i_sys_clk);
      #1;
      d = i_bus;
      wd = i_wbus;
      oe = i_bus_oe;
      busy = i_busy_pin;
      @(posedge i_sys_clk);
      #2;
      o_cs_n = 1'h1;
      o_rd_n = 1'h1;
   endtask
endmodule
`default_nettype wire

/* tb/tb_sar_adc_conversion_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_conversion_interface;
   import sar_adc_pkg::*;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [9:0] target = 10'h000;
   logic cs_n, wr_n, rd_n, bsel, conv_clk, cmp_high;
   logic [9:0] bus, wbus, dac;
   logic bus_oe, busy_out, busy_oe, done_out, done_oe;
   logic autozero, samp_pos, samp_neg;
   wire busy_pin;
   wire done_pin;
   int err_total = 0;
   int n_checks = 0;
   // open-drain pins with pull-ups
   assign busy_pin = busy_oe ? busy_out : 1'h1;
   assign done_pin = done_oe ? done_out : 1'h1;
   always #12.5 sys_clk = ~sys_clk;
   // ------------------------------------------------
   // instances
   // ------------------------------------------------
   sar_adc_conversion_interface #(.BYTE_VARIANT(1'h1)) u_dut (
      .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_conv_clk(conv_clk),
      .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
      .i_byte_select(bsel), .i_cmp_high(cmp_high),
      .o_result_bus_out(bus), .o_result_bus_oe(bus_oe),
      .o_busy_out(busy_out), .o_busy_oe(busy_oe),
      .o_done_out(done_out), .o_done_oe(done_oe),
      .o_dac_code(dac), .o_autozero(autozero),
      .o_sample_pos(samp_pos), .o_sample_neg(samp_neg)
   );
   // wide variant shares the host pins, only its bus is watched
   sar_adc_conversion_interface #(.BYTE_VARIANT(1'h0)) u_dut_wide (
      .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_conv_clk(conv_clk),
      .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
      .i_byte_select(bsel), .i_cmp_high(cmp_high),
      .o_result_bus_out(wbus), .o_result_bus_oe(),
      .o_busy_out(), .o_busy_oe(), .o_done_out(), .o_done_oe(),
      .o_dac_code(), .o_autozero(), .o_sample_pos(), .o_sample_neg()
   );
   host_model u_host (
      .i_sys_clk(sys_clk), .i_dac_code(dac), .i_target(target),
      .i_bus(bus), .i_wbus(wbus), .i_bus_oe(bus_oe),
      .i_busy_pin(busy_pin), .o_cs_n(cs_n), .o_wr_n(wr_n),
      .o_rd_n(rd_n), .o_byte_select(bsel), .o_conv_clk(conv_clk),
      .o_cmp_high(cmp_high)
   );
   // ------------------------------------------------
   // checks and scenarios
   // ------------------------------------------------
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic t_convert(input logic [9:0] val, input int w);
      realtime t0;
      int n;
      logic [9:0] d, wd;
      logic oe, busy;
      target = val;
      fork
         u_host.start(w, 1'h0);
         begin
            repeat (w + 1) @(posedge sys_clk);
            #1;
            chk(dac, DAC_FULL_SCALE);
            chk({8'h00, autozero, samp_pos}, 10'h003);
            chk({9'h000, done_pin}, 10'h001);
         end
      join
      t0 = $realtime;
      // hold point lies within 4 + 2.5 clocks of release
      repeat (130) @(posedge sys_clk);
      #1;
      chk({7'h00, samp_pos, samp_neg, done_pin}, 10'h003);
      chk({9'h000, busy_pin}, 10'h001);
      u_host.access(1'h1, 1'h0, d, wd, oe, busy);
      chk({9'h000, busy}, 10'h000);
      chk({4'h0, d[7:2]}, 10'h000);
      n = 0;
      while (done_pin !== 1'h0 && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      // 42..46 clocks of 16 cycles, small slack for synchronisers
      n = int'(($realtime - t0) / 25.0);
      chk({9'h000, n >= 666 && n <= 744}, 10'h001);
   endtask
   task automatic t_read(input logic [9:0] val);
      logic [9:0] d, wd;
      logic oe, busy;
      u_host.access(1'h1, 1'h0, d, wd, oe, busy);
      chk(d, {2'h0, 1'h1, 5'h00, val[9:8]});
      chk({8'h00, oe, busy}, 10'h003);
      u_host.access(1'h0, 1'h0, d, wd, oe, busy);
      chk(d, {2'h0, val[7:0]});
      chk(wd, val);
      repeat (4) @(posedge sys_clk);
      #1;
      chk({9'h000, bus_oe}, 10'h000);
   endtask
   task automatic t_idle();
      logic [9:0] d, wd;
      logic oe, busy;
      u_host.access(1'h0, 1'h1, d, wd, oe, busy);
      chk({9'h000, oe}, 10'h000);
      u_host.start(6, 1'h1);
      repeat (8) @(posedge sys_clk);
      #1;
      chk({9'h000, done_pin}, 10'h000);
   endtask
   task automatic finish_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // sequence and watchdog
   // ------------------------------------------------
   initial begin
      // about 2300 cycles of traffic; a hang is cut well beyond
      #500000;
      err_total++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      #2;
      rst_n = 1'h1;
      repeat (4) @(posedge sys_clk);
      t_convert(10'h2B5, 6);
      t_read(10'h2B5);
      t_idle();
      t_convert(10'h3FF, 5);
      t_read(10'h3FF);
      t_convert(10'h000, 9);
      t_read(10'h000);
      finish_test();
   end
endmodule
`default_nettype wire
